//--- design/tcg_core.sv
// Timecode generator core: frame counter, user bits, jam/restart, startup, calibration, auto record.
// Assumes all inputs synchronous to clk_sys; RTC date fields arrive as BCD bytes.
// Contract
// - user bits are eight hex digits
// - four user-bit layouts, only free pairs editable
// - seven selectable frame rates
// - slow non-drop rates run 0.1% slow
// - 29.97 drop skips frames to track real time
// - 30 drop numbering runs 0.1% fast
// - jam loads counter from external timecode
// - restart loads counter from preset value
// - auto record waits for continuous presence delay
// - stop at power-off, initialise at every startup
// - preset startup loads the restart preset
// - clock startup restores saved value, adds elapsed
// - calibration only in clock mode, refused otherwise
// - calibration trims power-off error
// - calibration result retained until replaced
// - auto record follows external timecode presence
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module tcg_core #(
	parameter int CLK_HZ = tcg_pkg::CLK_HZ,
	parameter int CAL_LOG2 = 4
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic ext_tc_valid,
	input wire tcg_pkg::tcg_tc_t ext_tc,
	input wire tcg_pkg::tcg_tc_t saved_tc,
	input wire logic [16:0] rtc_elapsed_s,
	input wire logic rtc_sec_pulse,
	input wire logic [7:0] rtc_year,
	input wire logic [7:0] rtc_month,
	input wire logic [7:0] rtc_day,
	input wire logic startup_from_preset_nv,
	input wire logic [31:0] cal_nv,
	input wire logic usb_backup_on,
	input wire logic remote_attached,
	input wire logic power_down,
	output tcg_pkg::tcg_tc_t tc_out,
	output logic [31:0] ubits_out,
	output logic tc_running,
	output logic rec_request,
	output logic [31:0] cal_result,
	output logic cal_store
);
	localparam int CAL_N = 1 << CAL_LOG2;
	localparam logic [31:0] CAL_TOTAL = 32'(CAL_N * CLK_HZ);
	localparam logic signed [31:0] HZ_S = 32'(CLK_HZ);
	localparam int MS_CYC = CLK_HZ / tcg_pkg::MS_PER_S;
	if (CAL_LOG2 < 1 || CAL_LOG2 > 5 || MS_CYC > 65536) $error("tcg_core: parameter out of range");

	// ==========================================================
	// Registers and state
	typedef enum {ST_BOOT, ST_ADVANCE, ST_RUN} tcg_st_t;
	typedef enum {CAL_IDLE, CAL_ARM, CAL_MEAS} tcg_cal_t;
	tcg_st_t st;
	tcg_cal_t cal_st;
	tcg_pkg::tcg_rate_t rate;
	tcg_pkg::tcg_ub_t ub_mode;
	logic startup_from_preset;
	logic auto_rec_en;
	tcg_pkg::tcg_tc_t preset;
	logic [31:0] ubits;
	logic [15:0] delay_ms;
	logic cal_refused;
	logic [16:0] adv_left;
	logic signed [31:0] err_acc;
	logic signed [31:0] next_err;
	logic [31:0] cal_cycles;
	logic [5:0] cal_pulses;
	logic [15:0] ms_count;
	logic [15:0] ms_pre;
	logic [4:0] top;
	logic drop;
	logic ctrl_wr;
	logic cmd_jam;
	logic cmd_restart;
	logic cmd_cal;
	logic cal_ok;
	tcg_tick_if tk ();

	assign ctrl_wr = wr && addr == tcg_pkg::A_CTRL;
	assign cmd_jam = ctrl_wr && wdata[tcg_pkg::C_JAM];
	assign cmd_restart = ctrl_wr && wdata[tcg_pkg::C_RESTART];
	assign cmd_cal = ctrl_wr && wdata[tcg_pkg::C_CAL];
	assign cal_ok = !startup_from_preset && !usb_backup_on && !remote_attached;
	assign tc_running = st == ST_RUN && !power_down;

	// ==========================================================
	// Rate decode: slow rates divide by 1001, drop rates skip labels
	always_comb
	begin
		tk.rate_num = tcg_pkg::NUM_30;
		tk.rate_den = tcg_pkg::DEN_EXACT;
		top = tcg_pkg::TOP_30;
		drop = 1'b0;
		case (rate)
			tcg_pkg::TCG_R23976ND:
			begin
				tk.rate_num = tcg_pkg::NUM_24;
				tk.rate_den = tcg_pkg::DEN_SLOW;
				top = tcg_pkg::TOP_24;
			end
			tcg_pkg::TCG_R24ND:
			begin
				tk.rate_num = tcg_pkg::NUM_24;
				top = tcg_pkg::TOP_24;
			end
			tcg_pkg::TCG_R25ND:
			begin
				tk.rate_num = tcg_pkg::NUM_25;
				top = tcg_pkg::TOP_25;
			end
			tcg_pkg::TCG_R2997ND: tk.rate_den = tcg_pkg::DEN_SLOW;
			tcg_pkg::TCG_R2997D:
			begin
				tk.rate_den = tcg_pkg::DEN_SLOW;
				drop = 1'b1;
			end
			tcg_pkg::TCG_R30ND: drop = 1'b0;
			tcg_pkg::TCG_R30D: drop = 1'b1;
			default: drop = 1'b0;
		endcase
	end
	assign tk.resync = st != ST_RUN || cmd_jam || cmd_restart;

	tcg_frame_tick #(.CLK_HZ(CLK_HZ)) u_tick (.clk_sys(clk_sys), .rst(rst), .tk(tk.gen));

	// ==========================================================
	// Counting helpers
	function automatic tcg_pkg::tcg_tc_t add_sec(input tcg_pkg::tcg_tc_t t);
		tcg_pkg::tcg_tc_t n;
		n = t;
		if (t.seconds < tcg_pkg::LAST_MINSEC)
			n.seconds = t.seconds + 6'h01;
		else
		begin
			n.seconds = '0;
			if (t.minutes < tcg_pkg::LAST_MINSEC)
				n.minutes = t.minutes + 6'h01;
			else
			begin
				n.minutes = '0;
				n.hours = (t.hours == tcg_pkg::LAST_HOUR) ? 5'h00 : t.hours + 5'h01;
			end
		end
		return n;
	endfunction : add_sec

	function automatic tcg_pkg::tcg_tc_t add_frame(input tcg_pkg::tcg_tc_t t, input logic [4:0] last,
		input logic skip);
		tcg_pkg::tcg_tc_t n;
		n = t;
		if (t.frames < last)
			n.frames = t.frames + 5'h01;
		else
		begin
			n = add_sec(t);
			n.frames = '0;
			// Labels 0 and 1 vanish at each minute except every tenth
			if (skip && n.seconds == 6'h00 && n.minutes % tcg_pkg::MIN_TENS != 6'h00)
				n.frames = tcg_pkg::DROP_COUNT;
		end
		return n;
	endfunction : add_frame

	// ==========================================================
	// Software-written configuration; startup mode is taken from the strap at boot
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			rate <= tcg_pkg::RATE_RESET;
			ub_mode <= tcg_pkg::TCG_UB_FREE;
			startup_from_preset <= 1'b1;
			auto_rec_en <= 1'b0;
		end
		else if (st == ST_BOOT)
			startup_from_preset <= startup_from_preset_nv;
		else if (ctrl_wr)
		begin
			rate <= tcg_pkg::tcg_rate_t'(wdata[tcg_pkg::C_RATE +: 3]);
			ub_mode <= tcg_pkg::tcg_ub_t'(wdata[tcg_pkg::C_UB +: 2]);
			startup_from_preset <= wdata[tcg_pkg::C_PRESET];
			auto_rec_en <= wdata[tcg_pkg::C_AUTOREC];
		end
	end

	// Preset, free user bits and record delay
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			preset <= '0;
			ubits <= '0;
			delay_ms <= tcg_pkg::DELAY_RESET;
		end
		else if (wr)
		begin
			if (addr == tcg_pkg::A_PRESET)
				preset <= wdata[21:0];
			if (addr == tcg_pkg::A_UBITS && ub_mode == tcg_pkg::TCG_UB_FREE)
				ubits <= wdata;
			else if (addr == tcg_pkg::A_UBITS)
				ubits[7:0] <= wdata[7:0];
			if (addr == tcg_pkg::A_DELAY)
				delay_ms <= wdata[15:0];
		end
	end

	// ==========================================================
	// Startup sequencer and the timecode counter itself
	assign next_err = err_acc + $signed(cal_result);
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st <= ST_BOOT;
			tc_out <= '0;
			adv_left <= '0;
			err_acc <= '0;
		end
		else
		begin
			case (st)
				ST_BOOT:
				begin
					err_acc <= '0;
					if (startup_from_preset_nv)
					begin
						tc_out <= preset;
						st <= ST_RUN;
					end
					else
					begin
						tc_out <= saved_tc;
						adv_left <= rtc_elapsed_s;
						st <= ST_ADVANCE;
					end
				end
				ST_ADVANCE:
				begin
					// One second per cycle; an extra trim second spends no clock second, so adds no drift
					if (adv_left == 17'h00000)
						st <= ST_RUN;
					else if (err_acc >= HZ_S)
					begin
						tc_out <= add_sec(tc_out);
						err_acc <= err_acc - HZ_S;
					end
					else if (err_acc <= -HZ_S)
					begin
						adv_left <= adv_left - 17'h00001;
						err_acc <= next_err + HZ_S;
					end
					else
					begin
						tc_out <= add_sec(tc_out);
						adv_left <= adv_left - 17'h00001;
						err_acc <= next_err;
					end
				end
				ST_RUN:
				begin
					if (cmd_jam && ext_tc_valid)
						tc_out <= ext_tc;
					else if (cmd_restart)
						tc_out <= preset;
					else if (tk.tick && !power_down)
						tc_out <= add_frame(tc_out, top, drop);
				end
				default: st <= ST_BOOT;
			endcase
		end
	end

	// ==========================================================
	// User bits output, date fields from the clock
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			ubits_out <= '0;
		else
		begin
			case (ub_mode)
				tcg_pkg::TCG_UB_MDY: ubits_out <= {rtc_month, rtc_day, rtc_year, ubits[7:0]};
				tcg_pkg::TCG_UB_DMY: ubits_out <= {rtc_day, rtc_month, rtc_year, ubits[7:0]};
				tcg_pkg::TCG_UB_YMD: ubits_out <= {rtc_year, rtc_month, rtc_day, ubits[7:0]};
				default: ubits_out <= ubits;
			endcase
		end
	end

	// ==========================================================
	// Calibration: measure system cycles over CAL_N clock seconds
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cal_st <= CAL_IDLE;
			cal_cycles <= '0;
			cal_pulses <= '0;
			cal_result <= '0;
			cal_store <= 1'b0;
		end
		else
		begin
			cal_store <= 1'b0;
			case (cal_st)
				CAL_IDLE:
				begin
					if (st == ST_BOOT)
						cal_result <= cal_nv;
					if (cmd_cal && cal_ok)
						cal_st <= CAL_ARM;
				end
				CAL_ARM:
				begin
					cal_cycles <= '0;
					cal_pulses <= '0;
					if (rtc_sec_pulse)
						cal_st <= CAL_MEAS;
				end
				CAL_MEAS:
				begin
					cal_cycles <= cal_cycles + 32'h00000001;
					if (rtc_sec_pulse)
						cal_pulses <= cal_pulses + 6'h01;
					if (rtc_sec_pulse && cal_pulses == 6'(CAL_N - 1))
					begin
						// Signed cycles of drift per clock second
						cal_result <= 32'($signed(cal_cycles + 32'h00000001 - CAL_TOTAL) >>> CAL_LOG2);
						cal_store <= 1'b1;
						cal_st <= CAL_IDLE;
					end
				end
				default: cal_st <= CAL_IDLE;
			endcase
		end
	end

	// Refusal flag; a new refusal wins over a clearing write
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			cal_refused <= 1'b0;
		else if (cmd_cal && !cal_ok)
			cal_refused <= 1'b1;
		else if (wr && addr == tcg_pkg::A_STATUS && wdata[tcg_pkg::S_REFUSED])
			cal_refused <= 1'b0;
	end

	// ==========================================================
	// Auto record: millisecond timer of continuous external presence
	always_ff @(posedge clk_sys)
	begin
		if (rst || !ext_tc_valid || !auto_rec_en)
		begin
			ms_pre <= '0;
			ms_count <= '0;
			rec_request <= 1'b0;
		end
		else
		begin
			if (ms_pre == 16'(MS_CYC - 1))
			begin
				ms_pre <= '0;
				if (ms_count != 16'hffff)
					ms_count <= ms_count + 16'h0001;
			end
			else
				ms_pre <= ms_pre + 16'h0001;
			rec_request <= ms_count >= delay_ms;
		end
	end

	// ==========================================================
	// Register read port, data one cycle after the strobe
	always_ff @(posedge clk_sys)
	begin
		if (rst || !rd)
			rdata <= '0;
		else
		begin
			case (addr)
				tcg_pkg::A_CTRL: rdata <= {20'h00000, auto_rec_en, startup_from_preset, ub_mode, 1'b0, rate, 4'h0};
				tcg_pkg::A_PRESET: rdata <= {10'h000, preset};
				tcg_pkg::A_UBITS: rdata <= ubits;
				tcg_pkg::A_DELAY: rdata <= {16'h0000, delay_ms};
				tcg_pkg::A_STATUS: rdata <= {27'h0000000, ext_tc_valid, rec_request, cal_refused,
					cal_st != CAL_IDLE, tc_running};
				tcg_pkg::A_TC: rdata <= {10'h000, tc_out};
				tcg_pkg::A_UBOUT: rdata <= ubits_out;
				tcg_pkg::A_CAL: rdata <= cal_result;
				default: rdata <= '0;
			endcase
		end
	end

	// ==========================================================
	// Checks
	sequence s_run_tick;
		st == ST_RUN && tk.tick && !power_down && !cmd_jam && !cmd_restart;
	endsequence
	sequence s_minute_end;
		tc_out.frames == top && tc_out.seconds == tcg_pkg::LAST_MINSEC;
	endsequence
	frame_advance_a: assert property (@(posedge clk_sys) disable iff (rst)
		s_run_tick |=> tc_out != $past(tc_out)) else $error("tick did not advance counter");
	drop_skip_a: assert property (@(posedge clk_sys) disable iff (rst)
		s_run_tick and s_minute_end and drop && tc_out.minutes % tcg_pkg::MIN_TENS != 6'h09
		|=> tc_out.frames == tcg_pkg::DROP_COUNT) else $error("drop frame labels not skipped");
	jam_load_a: assert property (@(posedge clk_sys) disable iff (rst)
		st == ST_RUN && cmd_jam && ext_tc_valid |=> tc_out == $past(ext_tc)) else $error("jam not loaded");
	restart_load_a: assert property (@(posedge clk_sys) disable iff (rst)
		st == ST_RUN && cmd_restart && !cmd_jam |=> tc_out == $past(preset)) else $error("restart not loaded");
	power_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		st == ST_RUN && power_down && !cmd_jam && !cmd_restart |=> $stable(tc_out)) else $error("counter ran at power-off");
	boot_preset_a: assert property (@(posedge clk_sys) disable iff (rst)
		st == ST_BOOT && startup_from_preset_nv |=> tc_out == $past(preset) && st == ST_RUN)
		else $error("preset startup failed");
	cal_refuse_a: assert property (@(posedge clk_sys) disable iff (rst)
		cal_st == CAL_IDLE && cmd_cal && !cal_ok |=> cal_st == CAL_IDLE && cal_refused) else $error("calibration not refused");
	rec_drop_a: assert property (@(posedge clk_sys) disable iff (rst)
		!ext_tc_valid |=> !rec_request) else $error("recording outlived external timecode");
	rec_delay_a: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(rec_request) |-> $past(ext_tc_valid) && $past(ms_count) >= delay_ms) else $error("recording started early");
	ub_layout_a: assert property (@(posedge clk_sys) disable iff (rst)
		ub_mode == tcg_pkg::TCG_UB_YMD ##1 ub_mode == tcg_pkg::TCG_UB_YMD
		|-> ubits_out[31:8] == {$past(rtc_year), $past(rtc_month), $past(rtc_day)}) else $error("date layout wrong");

endmodule : tcg_core

//--- design/tcg_pkg.sv
// Shared constants and types of the timecode generator.
// Assumes a single 50 MHz system clock and word-aligned 32-bit register access.
package tcg_pkg;

	// ==========================================================
	// Clock and time
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_NS = 20;
	localparam int MS_NS = 1_000_000;
	localparam int MS_CYCLES = MS_NS / CLK_NS;
	localparam int MS_PER_S = 1_000;

	// ==========================================================
	// Timecode word and counting limits
	typedef struct packed {
		logic [4:0] hours;
		logic [5:0] minutes;
		logic [5:0] seconds;
		logic [4:0] frames;
	} tcg_tc_t;
	localparam logic [4:0] LAST_HOUR = 5'h17;
	localparam logic [5:0] LAST_MINSEC = 6'h3b;
	localparam logic [5:0] MIN_TENS = 6'h0a;
	localparam logic [4:0] DROP_COUNT = 5'h02;
	localparam logic [4:0] TOP_24 = 5'h17;
	localparam logic [4:0] TOP_25 = 5'h18;
	localparam logic [4:0] TOP_30 = 5'h1d;
	localparam logic [16:0] NUM_24 = 17'h05dc0;
	localparam logic [16:0] NUM_25 = 17'h061a8;
	localparam logic [16:0] NUM_30 = 17'h07530;
	localparam logic [9:0] DEN_EXACT = 10'h3e8;
	localparam logic [9:0] DEN_SLOW = 10'h3e9;

	// ==========================================================
	// Modes
	typedef enum logic [2:0] {
		TCG_R23976ND, TCG_R24ND, TCG_R25ND, TCG_R2997ND, TCG_R2997D, TCG_R30ND, TCG_R30D
	} tcg_rate_t;
	typedef enum logic [1:0] {TCG_UB_FREE, TCG_UB_MDY, TCG_UB_DMY, TCG_UB_YMD} tcg_ub_t;

	// ==========================================================
	// Register map and fields
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_PRESET = 8'h04;
	localparam logic [7:0] A_UBITS = 8'h08;
	localparam logic [7:0] A_DELAY = 8'h0c;
	localparam logic [7:0] A_STATUS = 8'h10;
	localparam logic [7:0] A_TC = 8'h14;
	localparam logic [7:0] A_UBOUT = 8'h18;
	localparam logic [7:0] A_CAL = 8'h1c;
	localparam int C_JAM = 0;
	localparam int C_RESTART = 1;
	localparam int C_CAL = 2;
	localparam int C_RATE = 4;
	localparam int C_UB = 8;
	localparam int C_PRESET = 10;
	localparam int C_AUTOREC = 11;
	localparam int S_RUN = 0;
	localparam int S_CALBUSY = 1;
	localparam int S_REFUSED = 2;
	localparam int S_REC = 3;
	localparam int S_EXT = 4;
	localparam tcg_rate_t RATE_RESET = TCG_R24ND;
	localparam logic [15:0] DELAY_RESET = 16'h0000;

endpackage : tcg_pkg

//--- design/tcg_tick_if.sv
// Carrier between the timecode core and its frame-period generator.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface tcg_tick_if;
	logic [16:0] rate_num;
	logic [9:0] rate_den;
	logic resync;
	logic tick;
	modport ctl (output rate_num, output rate_den, output resync, input tick);
	modport gen (input rate_num, input rate_den, input resync, output tick);
endinterface : tcg_tick_if

//--- design/tcg_frame_tick.sv
// Frame-period generator: fractional phase accumulator giving one tick per frame.
// Assumes rate_num is frames per second times one thousand, rate_den 1000 or 1001.
`timescale 1ns/1ps
module tcg_frame_tick #(
	parameter int CLK_HZ = tcg_pkg::CLK_HZ
) (
	input wire logic clk_sys,
	input wire logic rst,
	tcg_tick_if.gen tk
);
	if (CLK_HZ < 100_000) $error("tcg_frame_tick: clock too slow for frame rates");

	// ==========================================================
	// Phase accumulator
	localparam logic [35:0] HZ36 = 36'(CLK_HZ);
	logic [35:0] acc;
	logic [35:0] lim;
	logic [35:0] next_acc;
	assign lim = HZ36 * 36'(tk.rate_den);
	assign next_acc = acc + 36'(tk.rate_num);

	// Remainder is kept, so the long-run rate is exact to the clock
	always_ff @(posedge clk_sys)
	begin
		if (rst || tk.resync)
		begin
			acc <= '0;
			tk.tick <= 1'b0;
		end
		else if (next_acc >= lim)
		begin
			acc <= next_acc - lim;
			tk.tick <= 1'b1;
		end
		else
		begin
			acc <= next_acc;
			tk.tick <= 1'b0;
		end
	end

	sequence s_tick;
		tk.tick;
	endsequence
	tick_spacing_a: assert property (@(posedge clk_sys) disable iff (rst) s_tick |=> !tk.tick)
		else $error("frame ticks back to back");

endmodule : tcg_frame_tick

//--- verif/tcg_ext_src.sv
// Model of the external timecode source feeding the timecode core.
// Assumes one clock shared with the core; run is driven by the bench.
`timescale 1ns/1ps
module tcg_ext_src #(
	parameter int FRAME_CYC = 40
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic run,
	output logic ext_tc_valid,
	output tcg_pkg::tcg_tc_t ext_tc
);
	tcg_pkg::tcg_tc_t cur;
	int cnt;

	// ==========================================================
	// Running source, frames carry into seconds at 25 fps
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cur <= {5'h02, 6'h11, 6'h05, 5'h03};
			cnt <= 0;
			ext_tc_valid <= 1'b0;
		end
		else
		begin
			ext_tc_valid <= run;
			cnt <= (cnt == FRAME_CYC - 1) ? 0 : cnt + 1;
			if (run && cnt == FRAME_CYC - 1)
			begin
				cur.frames <= (cur.frames == 5'h18) ? 5'h00 : cur.frames + 5'h01;
				cur.seconds <= (cur.frames == 5'h18) ? cur.seconds + 6'h01 : cur.seconds;
			end
		end
	end

	// Released line shows the complement of the held value, so a stale value can never pass as fresh
	always_comb
	begin
		ext_tc = ext_tc_valid ? cur : ~cur;
	end
endmodule : tcg_ext_src

//--- verif/timecode_generator_test.sv
// Self-checking bench of the timecode core: boot, counting, commands, user bits, auto record.
// Assumes the handed-over register map; CLK_HZ is lowered so frames last a few thousand cycles.
`timescale 1ns/1ps
module timecode_generator_test;
	localparam int HZ = 100000;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata, ubits_out, cal_result, r;
	logic ext_tc_valid, tc_running, rec_request, cal_store;
	tcg_pkg::tcg_tc_t ext_tc, tc_out, at_take;
	tcg_pkg::tcg_tc_t saved_tc = {5'h01, 6'h02, 6'h03, 5'h04};
	logic [7:0] rtc_year = 8'h25;
	logic [7:0] rtc_month = 8'h07;
	logic [7:0] rtc_day = 8'h19;
	logic startup_from_preset_nv = 1'b0;
	logic usb_backup_on = 1'b0;
	logic remote_attached = 1'b0;
	logic power_down = 1'b0;
	logic sec_pulse = 1'b0;
	logic [31:0] cal_nv = 32'h00000003;
	logic src_run = 1'b0;
	logic [2:0] cfg_rate = 3'h1;
	logic [1:0] cfg_ub = 2'h0;
	logic cfg_ar = 1'b0;
	logic cfg_sp = 1'b0;
	int err_total = 0;
	int n_compared = 0;
	int cyc = 0;

	// ==========================================================
	// Clock, design and partner
	always #10 clk_sys = ~clk_sys;

	tcg_core #(.CLK_HZ(HZ), .CAL_LOG2(1)) dut_u (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .ext_tc_valid(ext_tc_valid), .ext_tc(ext_tc), .saved_tc(saved_tc),
		.rtc_elapsed_s(17'h00005), .rtc_sec_pulse(sec_pulse), .rtc_year(rtc_year), .rtc_month(rtc_month),
		.rtc_day(rtc_day), .startup_from_preset_nv(startup_from_preset_nv), .cal_nv(cal_nv),
		.usb_backup_on(usb_backup_on), .remote_attached(remote_attached), .power_down(power_down),
		.tc_out(tc_out), .ubits_out(ubits_out), .tc_running(tc_running), .rec_request(rec_request),
		.cal_result(cal_result), .cal_store(cal_store));

	tcg_ext_src src_u (.clk_sys(clk_sys), .rst(rst), .run(src_run), .ext_tc_valid(ext_tc_valid), .ext_tc(ext_tc));

	// ==========================================================
	// Shared tasks
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Source value is read at the take edge, before that edge's updates land
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		at_take = ext_tc;
		wr <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : bus_rd

	function automatic logic [31:0] ctl(input logic [2:0] cmd);
		return {20'h0, cfg_ar, cfg_sp, cfg_ub, 1'b0, cfg_rate, 1'b0, cmd};
	endfunction : ctl

	// Bounded wait for the next change of the counter, returning cycles waited
	task automatic wait_tick(output int n);
		tcg_pkg::tcg_tc_t p;
		p = tc_out;
		n = 0;
		while (tc_out === p && n < 5000)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask : wait_tick

	task automatic restart(input logic [21:0] v);
		bus_wr(tcg_pkg::A_PRESET, {10'h0, v});
		bus_wr(tcg_pkg::A_CTRL, ctl(3'h2));
		@(posedge clk_sys);
		#1;
		chk("restart value", {10'h0, v}, {10'h0, tc_out});
	endtask : restart

	// Rollover value and then one full frame period at the chosen rate
	task automatic frame_case(input logic [2:0] rt, input logic [21:0] st, input logic [21:0] ex, input int lo);
		int n;
		cfg_rate = rt;
		restart(st);
		wait_tick(n);
		chk("rollover value", {10'h0, ex}, {10'h0, tc_out});
		wait_tick(n);
		chk("frame period", 32'h1, {31'h0, n >= lo && n <= lo + 1});
	endtask : frame_case

	// ==========================================================
	// Scenarios
	task automatic boot_rtc();
		int n;
		n = 0;
		while (tc_running !== 1'b1 && n < 200)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk("running after boot", 32'h1, {31'h0, tc_running});
		chk("advanced start", {10'h0, 5'h01, 6'h02, 6'h08, 5'h04}, {10'h0, tc_out});
		chk("kept calibration", 32'h3, cal_result);
		bus_rd(8'h20, r);
		chk("unmapped read", 32'h0, r);
		bus_rd(tcg_pkg::A_CTRL, r);
		chk("control reset", 32'h10, r);
		bus_rd(tcg_pkg::A_STATUS, r);
		chk("status running", 32'h1, r);
	endtask : boot_rtc

	task automatic frames();
		frame_case(3'h1, {5'h17, 6'h3b, 6'h3b, 5'h17}, 22'h0, 16'h1046);
		frame_case(3'h0, {5'h00, 6'h00, 6'h00, 5'h17}, {5'h00, 6'h00, 6'h01, 5'h00}, 16'h104a);
		frame_case(3'h2, {5'h00, 6'h00, 6'h00, 5'h18}, {5'h00, 6'h00, 6'h01, 5'h00}, 16'h0fa0);
		frame_case(3'h3, {5'h00, 6'h00, 6'h3b, 5'h1d}, {5'h00, 6'h01, 6'h00, 5'h00}, 16'h0d08);
		frame_case(3'h4, {5'h00, 6'h00, 6'h3b, 5'h1d}, {5'h00, 6'h01, 6'h00, 5'h02}, 16'h0d08);
		frame_case(3'h5, {5'h00, 6'h00, 6'h3b, 5'h1d}, {5'h00, 6'h01, 6'h00, 5'h00}, 16'h0d05);
		frame_case(3'h6, {5'h00, 6'h00, 6'h3b, 5'h1d}, {5'h00, 6'h01, 6'h00, 5'h02}, 16'h0d05);
		frame_case(3'h6, {5'h00, 6'h09, 6'h3b, 5'h1d}, {5'h00, 6'h0a, 6'h00, 5'h00}, 16'h0d05);
	endtask : frames

	task automatic ubits();
		logic [31:0] e;
		bus_wr(tcg_pkg::A_UBITS, 32'h9a0fc35e);
		bus_rd(tcg_pkg::A_UBOUT, r);
		chk("free user bits", 32'h9a0fc35e, r);
		for (int m = 1; m < 4; m++)
		begin
			cfg_ub = m[1:0];
			bus_wr(tcg_pkg::A_CTRL, ctl(3'h0));
			bus_wr(tcg_pkg::A_UBITS, 32'h123456ab);
			repeat (2) @(posedge clk_sys);
			#1;
			e = (m == 1) ? 32'h071925ab : (m == 2) ? 32'h190725ab : 32'h250719ab;
			chk("dated user bits", e, ubits_out);
		end
		cfg_ub = 2'h0;
		bus_wr(tcg_pkg::A_CTRL, ctl(3'h0));
	endtask : ubits

	// The jam itself resyncs the frame tick, so no frame tick can land between the two checks
	task automatic jam_cases();
		tcg_pkg::tcg_tc_t held;
		src_run <= 1'b1;
		repeat (50) @(posedge clk_sys);
		bus_wr(tcg_pkg::A_CTRL, ctl(3'h1));
		held = at_take;
		@(posedge clk_sys);
		#1;
		chk("jammed value", {10'h0, held}, {10'h0, tc_out});
		@(posedge clk_sys);
		src_run <= 1'b0;
		repeat (3) @(posedge clk_sys);
		bus_wr(tcg_pkg::A_CTRL, ctl(3'h1));
		@(posedge clk_sys);
		#1;
		chk("jam without source", {10'h0, held}, {10'h0, tc_out});
	endtask : jam_cases

	task automatic power_off();
		tcg_pkg::tcg_tc_t held;
		@(posedge clk_sys);
		power_down <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk("running while off", 32'h0, {31'h0, tc_running});
		held = tc_out;
		repeat (4500) @(posedge clk_sys);
		#1;
		chk("frozen while off", {10'h0, held}, {10'h0, tc_out});
		@(posedge clk_sys);
		power_down <= 1'b0;
	endtask : power_off

	task automatic autorec();
		int n;
		cfg_ar = 1'b1;
		bus_wr(tcg_pkg::A_DELAY, 32'h0);
		bus_wr(tcg_pkg::A_CTRL, ctl(3'h0));
		src_run <= 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		chk("record on source", 32'h1, {31'h0, rec_request});
		bus_rd(tcg_pkg::A_STATUS, r);
		chk("status source and record", 32'h18, r & 32'h18);
		@(posedge clk_sys);
		src_run <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		chk("record stops", 32'h0, {31'h0, rec_request});
		bus_wr(tcg_pkg::A_DELAY, 32'h1);
		src_run <= 1'b1;
		n = 0;
		// One ms of presence, plus an edge for the source and one for the request
		repeat (HZ / 1000 + 1)
		begin
			@(posedge clk_sys);
			#1;
			n += int'(rec_request === 1'b1);
		end
		chk("short burst ignored", 32'h0, n);
		@(posedge clk_sys);
		#1;
		chk("record after delay", 32'h1, {31'h0, rec_request});
		@(posedge clk_sys);
		src_run <= 1'b0;
		cfg_ar = 1'b0;
	endtask : autorec

	task automatic cal_refuse();
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk_sys);
			usb_backup_on <= (k == 0);
			remote_attached <= (k == 1);
			cfg_sp = (k == 2);
			bus_wr(tcg_pkg::A_CTRL, ctl(3'h0));
			bus_wr(tcg_pkg::A_CTRL, ctl(3'h4));
			bus_rd(tcg_pkg::A_STATUS, r);
			chk("calibration gate", (k < 3) ? 32'h4 : 32'h2, r & 32'h6);
			bus_wr(tcg_pkg::A_STATUS, 32'h4);
		end
	endtask : cal_refuse

	// Clock seconds ten cycles long: drift is ten cycles minus a nominal second
	task automatic cal_measure();
		int n;
		n = 0;
		for (int p = 0; p < 30; p++)
		begin
			@(posedge clk_sys);
			sec_pulse <= (p % 10 == 0);
			#1;
			n += int'(cal_store === 1'b1);
		end
		chk("calibration result", 32'(10 - HZ), cal_result);
		chk("calibration stored", 32'h1, n);
	endtask : cal_measure

	task automatic boot_preset();
		@(posedge clk_sys);
		startup_from_preset_nv <= 1'b1;
		rst <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		chk("preset start", 32'h0, {10'h0, tc_out});
		chk("running after preset boot", 32'h1, {31'h0, tc_running});
		chk("calibration reloaded", 32'h3, cal_result);
		// Half a second of drift per clock second: two extra seconds over five
		@(posedge clk_sys);
		startup_from_preset_nv <= 1'b0;
		cal_nv <= 32'(HZ / 2);
		rst <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (12) @(posedge clk_sys);
		#1;
		chk("trimmed start", {10'h0, 5'h01, 6'h02, 6'h0a, 5'h04}, {10'h0, tc_out});
	endtask : boot_preset

	// ==========================================================
	// Sequence and hang guard
	initial
	begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		boot_rtc();
		frames();
		ubits();
		jam_cases();
		power_off();
		autorec();
		cal_refuse();
		cal_measure();
		boot_preset();
		print_verdict();
	end

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 95000)
		begin
			err_total++;
			print_verdict();
		end
	end
endmodule : timecode_generator_test
